// ### sim/dtc_assertions.sv
module dtc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic second_overflow_pulse,
  input wire logic irq
);
  logic [7:0] mode_sh;
  logic [1:0] mask_sh;
  wire wr_ok = psel && penable && pready && pwrite;
  // shadows follow only committed writes, so a refused access cannot move them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_sh <= 8'h00;
      mask_sh <= 2'h0;
    end else begin
      if (wr_ok && paddr == dtc_pkg::mode_off) mode_sh <= pwdata[7:0];
      if (wr_ok && paddr == dtc_pkg::mask_off) mask_sh <= pwdata[1:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////
  property p_ready_wait; psel && penable && !pready |=> pready; endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no ready after access");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_setup_quiet; $rose(psel) |-> !pready; endproperty
  a_setup_quiet: assert property (p_setup_quiet) else $error("ready in setup");
  property p_err_ready; pslverr |-> pready; endproperty
  a_err_ready: assert property (p_err_ready) else $error("error without ready");
  property p_idle_zero; !pready |-> prdata == 32'h0; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("read data while idle");
  property p_upper_zero; prdata[31:8] == 24'h0; endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits set");
  property p_irq_mask; irq |-> $past(mask_sh) != 2'h0; endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("irq while masked");
  property p_hold_quiet;
    mode_sh[5:4] == 2'h3 && $past(mode_sh[5:4]) == 2'h3 && $past(mode_sh[5:4], 2) == 2'h3
      && $past(mode_sh[5:4], 3) == 2'h3 |-> !second_overflow_pulse;
  endproperty
  a_hold_quiet: assert property (p_hold_quiet) else $error("held timer overflowed");
  c_irq: cover property (irq);
  c_pulse: cover property (second_overflow_pulse);
  c_err: cover property (pslverr);
endmodule
bind dtc_top dtc_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .second_overflow_pulse, .irq);

// ### sim/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic qual1 = 0, qual2 = 0, cnt1 = 0, cnt2 = 0, pready, pslverr, sop, irq, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int miscompares, check_count;
  always #25 pclk = ~pclk;
  dtc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .external_qualify_pin(qual1), .second_qualify_pin(qual2), .first_count_input(cnt1),
    .second_count_input(cnt2), .second_overflow_pulse(sop), .irq);
  ////////////////////////////////////////////////////////////
  task summarize;
    $display("miscompares %0d check_count %0d", miscompares, check_count);
    if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      $display("wrong value at %0t: %s got %h", $time, m, got);
      miscompares++;
    end
  endtask
  // master holds the request until ready is seen, then idles one edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      miscompares++;
      summarize();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] exp, input string m);
    xfer(1'b0, a, 32'h0);
    chk(q, exp, m);
  endtask
  task wait_on(input int lim, input bit use_irq, input string m);
    int n;
    n = 0;
    while ((use_irq ? irq : sop) !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk(32'(use_irq ? irq : sop), 32'h1, m);
    if ((use_irq ? irq : sop) !== 1'b1) summarize();
  endtask
  ////////////////////////////////////////////////////////////
  task t_regs;
    rd(dtc_pkg::status_off, 32'h0, "status rst");
    rd(dtc_pkg::mode_off, 32'h0, "mode rst");
    rd(12'h020, 32'h0, "unmapped");
    chk(32'(err), 32'h1, "slverr");
  endtask
  task t_run;
    wr(dtc_pkg::first_low_off, 32'h20);
    wr(dtc_pkg::mode_off, 32'h01);
    wr(dtc_pkg::ctrl_off, 32'h1);
    repeat (9) @(posedge pclk);
    wr(dtc_pkg::ctrl_off, 32'h0);
    rd(dtc_pkg::first_low_off, 32'h2d, "run count");
  endtask
  // mode 0 bound of 20 would not reach a 16-bit rollover from ff1e
  task t_roll(input logic [31:0] md, input logic [31:0] lo, input int lim);
    wr(dtc_pkg::mask_off, 32'h3);
    wr(dtc_pkg::mode_off, md);
    wr(dtc_pkg::first_high_off, 32'hff);
    wr(dtc_pkg::first_low_off, lo);
    wr(dtc_pkg::ctrl_off, 32'h1);
    wait_on(lim, 1'b1, "irq");
    wr(dtc_pkg::ctrl_off, 32'h0);
    rd(dtc_pkg::status_off, 32'h1, "flag");
    rd(dtc_pkg::first_high_off, 32'h0, "high wrap");
    wr(dtc_pkg::status_off, 32'h1);
    repeat (2) @(posedge pclk);
    chk(32'(irq), 32'h0, "irq clear");
  endtask
  task t_reload;
    wr(dtc_pkg::mode_off, 32'h02);
    wr(dtc_pkg::first_high_off, 32'hf0);
    wr(dtc_pkg::first_low_off, 32'hfd);
    wr(dtc_pkg::ctrl_off, 32'h1);
    wait_on(20, 1'b1, "reload irq");
    repeat (30) @(posedge pclk);
    wr(dtc_pkg::ctrl_off, 32'h0);
    rd(dtc_pkg::first_high_off, 32'hf0, "high kept");
    rd(dtc_pkg::first_low_off, 32'hf3, "low");
    chk({28'h0, q[7:4]}, 32'hf, "low reloaded");
    wr(dtc_pkg::status_off, 32'h3);
  endtask
  task t_gate;
    wr(dtc_pkg::mode_off, 32'h09);
    wr(dtc_pkg::first_low_off, 32'h0);
    wr(dtc_pkg::ctrl_off, 32'h1);
    repeat (5) @(posedge pclk);
    wr(dtc_pkg::ctrl_off, 32'h0);
    rd(dtc_pkg::first_low_off, 32'h0, "gated");
    qual1 <= 1'b1;
    wr(dtc_pkg::ctrl_off, 32'h1);
    repeat (9) @(posedge pclk);
    wr(dtc_pkg::ctrl_off, 32'h0);
    rd(dtc_pkg::first_low_off, 32'h0d, "pin high");
    wr(dtc_pkg::mode_off, 32'h05);
    wr(dtc_pkg::first_low_off, 32'h0);
    wr(dtc_pkg::ctrl_off, 32'h1);
    repeat (3) begin
      cnt1 <= 1'b1;
      @(posedge pclk);
      cnt1 <= 1'b0;
      @(posedge pclk);
    end
    wr(dtc_pkg::ctrl_off, 32'h0);
    rd(dtc_pkg::first_low_off, 32'h03, "count pin edges");
  endtask
  task t_split;
    wr(dtc_pkg::second_low_off, 32'h55);
    wr(dtc_pkg::first_high_off, 32'hfe);
    wr(dtc_pkg::first_low_off, 32'h11);
    wr(dtc_pkg::mode_off, 32'h33);
    wr(dtc_pkg::ctrl_off, 32'h2);
    repeat (10) @(posedge pclk);
    wr(dtc_pkg::ctrl_off, 32'h0);
    rd(dtc_pkg::second_low_off, 32'h55, "second held");
    rd(dtc_pkg::first_low_off, 32'h11, "low own run");
    rd(dtc_pkg::status_off, 32'h2, "high sets second");
    wr(dtc_pkg::status_off, 32'h3);
    wr(dtc_pkg::second_high_off, 32'hff);
    wr(dtc_pkg::second_low_off, 32'h1e);
    wr(dtc_pkg::mode_off, 32'h03);
    wait_on(20, 1'b0, "second runs");
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_run();
    t_roll(32'h01, 32'hf0, 40);
    t_roll(32'h00, 32'h1e, 20);
    t_reload();
    t_gate();
    t_split();
    summarize();
  end
endmodule

// ### src/dtc_counter.sv
module dtc_counter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] mode,
  input wire logic low_en,
  input wire logic high_en,
  input wire logic hold_all,
  input wire logic wr_low,
  input wire logic wr_high,
  input wire logic [7:0] wdata,
  output logic [7:0] low_q,
  output logic [7:0] high_q,
  output logic low_ovf,
  output logic high_ovf
);
  logic [7:0] low_reg;
  logic [7:0] high_reg;
  logic [7:0] low_next;
  logic [7:0] high_next;
  logic low_ovf_next;
  logic high_ovf_next;
  logic [4:0] low5;

  assign low5 = low_reg[4:0];

  always_comb begin
    low_next = low_reg;
    high_next = high_reg;
    low_ovf_next = 1'b0;
    high_ovf_next = 1'b0;
    if (!hold_all) begin
      case (mode)
        2'b00: begin
          if (low_en) begin
            low_next = {low_reg[7:5], 5'(low5 + 5'h01)};
            if (low5 == 5'h1f) begin
              high_next = 8'(high_reg + 8'h01);
              low_ovf_next = (high_reg == 8'hff);
            end
          end
        end
        2'b01: begin
          if (low_en) begin
            low_next = 8'(low_reg + 8'h01);
            if (low_reg == 8'hff) begin
              high_next = 8'(high_reg + 8'h01);
              low_ovf_next = (high_reg == 8'hff);
            end
          end
        end
        2'b10: begin
          if (low_en) begin
            if (low_reg == 8'hff) begin
              low_next = high_reg;
              low_ovf_next = 1'b1;
            end else begin
              low_next = 8'(low_reg + 8'h01);
            end
          end
        end
        2'b11: begin
          if (low_en) begin
            low_next = 8'(low_reg + 8'h01);
            low_ovf_next = (low_reg == 8'hff);
          end
          if (high_en) begin
            high_next = 8'(high_reg + 8'h01);
            high_ovf_next = (high_reg == 8'hff);
          end
        end
        default: begin
          low_next = low_reg;
        end
      endcase
    end
    // software write overrides counting in that cycle
    if (wr_low) begin
      low_next = wdata;
    end
    if (wr_high) begin
      high_next = wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_reg <= dtc_pkg::byte_reset;
      high_reg <= dtc_pkg::byte_reset;
      low_ovf <= 1'b0;
      high_ovf <= 1'b0;
    end else begin
      low_reg <= low_next;
      high_reg <= high_next;
      low_ovf <= low_ovf_next;
      high_ovf <= high_ovf_next;
    end
  end

  assign low_q = low_reg;
  assign high_q = high_reg;
endmodule

// ### src/dtc_pkg.sv
package dtc_pkg;
  // register byte offsets
  localparam logic [11:0] ctrl_off = 12'h000;
  localparam logic [11:0] mode_off = 12'h004;
  localparam logic [11:0] first_low_off = 12'h008;
  localparam logic [11:0] first_high_off = 12'h00c;
  localparam logic [11:0] second_low_off = 12'h010;
  localparam logic [11:0] second_high_off = 12'h014;
  localparam logic [11:0] status_off = 12'h018;
  localparam logic [11:0] mask_off = 12'h01c;
  // control bit positions
  localparam int ctrl_run_first_bit = 0;
  localparam int ctrl_run_second_bit = 1;
  // mode register layout: per timer gate at bit 3, count source at bit 2, mode at 1:0
  localparam int mode_second_base = 4;
  localparam int mode_gate_bit = 3;
  localparam int mode_src_bit = 2;
  // status / mask bits
  localparam int stat_first_bit = 0;
  localparam int stat_second_bit = 1;
  // reset values
  localparam logic [7:0] byte_reset = 8'h00;
  localparam logic [1:0] two_reset = 2'h0;
  localparam logic [7:0] mode_reset = 8'h00;
  // count increment per enabled clock cycle: no prescaler
  localparam int prescale_cycles = 1;
  typedef enum logic [1:0] {
    dtc_mode13_type = 2'b00,
    dtc_mode16_type = 2'b01,
    dtc_mode8r_type = 2'b10,
    dtc_split_type = 2'b11
  } dtc_mode_type;
endpackage

// ### src/dtc_top.sv
// Overview of operation
// - timers share modes 0 to 2; mode 3 splits the first, holds the second
// - count every core clock, no prescaler
// - mode 0: 13-bit count, low top ignored
// - rollover to zero sets overflow flag
// - count when run and (no gate or pin)
// - setting run leaves count registers untouched
// - mode 1: full 16-bit counter
// - mode 2: low byte reloads from high
// - second timer in mode 3 holds count
// - split mode low byte uses first controls
// - split high byte uses second run, flag
// - second timer starts/stops via its mode 3
//
// The implementer's own choices: the APB register port and the placing of the registers.
module dtc_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_qualify_pin,
  input wire logic second_qualify_pin,
  input wire logic first_count_input,
  input wire logic second_count_input,
  output logic second_overflow_pulse,
  output logic irq
);
  ////////////////////////////////////////////////////////////////////////////
  logic [1:0] timer_control_register_reg;
  logic [7:0] timer_mode_register_reg;
  logic [1:0] status_reg;
  logic [1:0] mask_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic irq_reg;
  logic ovf_pulse_reg;
  logic first_cnt_in_reg;
  logic second_cnt_in_reg;

  logic [7:0] first_low_byte;
  logic [7:0] first_high_byte;
  logic [7:0] second_low_q;
  logic [7:0] second_high_q;
  logic first_low_ovf;
  logic first_high_ovf;
  logic second_low_ovf;
  logic second_high_ovf;

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  wire access = psel && penable;
  wire wr_acc = access && pwrite;
  // writes land only at the edge that completes the access, never in the wait state
  wire wr_commit = wr_acc && pready_reg;
  wire hit_ctrl = paddr == dtc_pkg::ctrl_off;
  wire hit_mode = paddr == dtc_pkg::mode_off;
  wire hit_fl = paddr == dtc_pkg::first_low_off;
  wire hit_fh = paddr == dtc_pkg::first_high_off;
  wire hit_sl = paddr == dtc_pkg::second_low_off;
  wire hit_sh = paddr == dtc_pkg::second_high_off;
  wire hit_stat = paddr == dtc_pkg::status_off;
  wire hit_mask = paddr == dtc_pkg::mask_off;
  wire mapped = hit_ctrl | hit_mode | hit_fl | hit_fh | hit_sl | hit_sh | hit_stat | hit_mask;

  ////////////////////////////////////////////////////////////////////////////
  // mode fields
  wire [1:0] first_mode = timer_mode_register_reg[1:0];
  wire first_src = timer_mode_register_reg[dtc_pkg::mode_src_bit];
  wire first_gate = timer_mode_register_reg[dtc_pkg::mode_gate_bit];
  wire [1:0] second_mode = timer_mode_register_reg[dtc_pkg::mode_second_base +: 2];
  wire second_src = timer_mode_register_reg[dtc_pkg::mode_second_base + dtc_pkg::mode_src_bit];
  wire second_gate = timer_mode_register_reg[dtc_pkg::mode_second_base + dtc_pkg::mode_gate_bit];
  wire run_control_first = timer_control_register_reg[dtc_pkg::ctrl_run_first_bit];
  wire run_control_second = timer_control_register_reg[dtc_pkg::ctrl_run_second_bit];
  wire first_split = first_mode == dtc_pkg::dtc_split_type;

  // count source: core clock when src is 0, else rising edge of the count input
  // count input is treated as synchronous; an edge counts at the next clock, with no extra cycle
  function automatic logic tick(input logic src, input logic pin_now, input logic pin_last);
    tick = src ? (pin_now && !pin_last) : 1'b1;
  endfunction

  function automatic logic allowed(input logic run, input logic gate, input logic qual);
    allowed = run && (!gate || qual);
  endfunction

  wire first_low_en = allowed(run_control_first, first_gate, external_qualify_pin)
    && tick(first_src, first_count_input, first_cnt_in_reg);
  // split mode high byte counts core clocks only, run by the second run bit
  wire first_high_en = run_control_second;
  // while the first timer is split, the second loses its run bit and runs unless in mode 3
  wire second_run_eff = first_split ? 1'b1 : run_control_second;
  wire second_low_en = allowed(second_run_eff, second_gate, second_qualify_pin)
    && tick(second_src, second_count_input, second_cnt_in_reg);
  wire second_hold = second_mode == dtc_pkg::dtc_split_type;

  // overflow events: split mode high byte owns the second flag
  wire ev_first = first_low_ovf;
  wire ev_second = first_split ? first_high_ovf : second_low_ovf;

  wire [1:0] events = {ev_second, ev_first};
  wire [1:0] clear_bits = (wr_commit && hit_stat) ? pwdata[1:0] : 2'h0;
  // set wins over clear in the same cycle
  wire [1:0] status_next = (status_reg & ~clear_bits) | events;

  ////////////////////////////////////////////////////////////////////////////
  dtc_counter u_first (
    .pclk(pclk),
    .presetn(presetn),
    .mode(first_mode),
    .low_en(first_low_en),
    .high_en(first_high_en),
    .hold_all(1'b0),
    .wr_low(wr_commit && hit_fl),
    .wr_high(wr_commit && hit_fh),
    .wdata(pwdata[7:0]),
    .low_q(first_low_byte),
    .high_q(first_high_byte),
    .low_ovf(first_low_ovf),
    .high_ovf(first_high_ovf)
  );

  dtc_counter u_second (
    .pclk(pclk),
    .presetn(presetn),
    .mode(second_mode),
    .low_en(second_low_en),
    .high_en(1'b0),
    .hold_all(second_hold),
    .wr_low(wr_commit && hit_sl),
    .wr_high(wr_commit && hit_sh),
    .wdata(pwdata[7:0]),
    .low_q(second_low_q),
    .high_q(second_high_q),
    .low_ovf(second_low_ovf),
    .high_ovf()
  );

  ////////////////////////////////////////////////////////////////////////////
  wire [31:0] rd_mux =
    hit_ctrl ? {30'h0, timer_control_register_reg} :
    hit_mode ? {24'h0, timer_mode_register_reg} :
    hit_fl ? {24'h0, first_low_byte} :
    hit_fh ? {24'h0, first_high_byte} :
    hit_sl ? {24'h0, second_low_q} :
    hit_sh ? {24'h0, second_high_q} :
    hit_stat ? {30'h0, status_reg} :
    hit_mask ? {30'h0, mask_reg} : 32'h0;

  // one wait state: ready is raised at the end of the first access cycle, answer at the second edge
  wire ready_next = access && !pready_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_control_register_reg <= dtc_pkg::two_reset;
      timer_mode_register_reg <= dtc_pkg::mode_reset;
      mask_reg <= dtc_pkg::two_reset;
    end else if (wr_commit) begin
      // run bit write touches only control, never the count bytes
      if (hit_ctrl) timer_control_register_reg <= pwdata[1:0];
      if (hit_mode) timer_mode_register_reg <= pwdata[7:0];
      if (hit_mask) mask_reg <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= dtc_pkg::two_reset;
      irq_reg <= 1'b0;
      ovf_pulse_reg <= 1'b0;
      first_cnt_in_reg <= 1'b0;
      second_cnt_in_reg <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg <= |(status_next & mask_reg);
      ovf_pulse_reg <= second_low_ovf;
      first_cnt_in_reg <= first_count_input;
      second_cnt_in_reg <= second_count_input;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      pready_reg <= ready_next;
      pslverr_reg <= ready_next && !mapped;
      prdata_reg <= (ready_next && !pwrite) ? rd_mux : 32'h0;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign second_overflow_pulse = ovf_pulse_reg;
endmodule
